/* hw/dcphp_host_port.sv */
/*
 * the processor side port: chip select, strobes, two address lines, 16-bit
 * data split into in, out and enable, two dma request/ack channels, eot.
 * assumes strobes and address stay put for at least three clock cycles and
 * that chip select or ack is held until the strobe has returned high.
 */
module dcphp_host_port #(
    parameter int FIFO_DEPTH = 64,                 // words per controller fifo
    parameter logic [15:0] CHIP_ID = 16'h5A5A      // arbitrary value
) (
    // clock and reset
    input wire logic clk,
    input wire logic rstn,
    // processor bus
    input wire logic csN,
    input wire logic rdN,
    input wire logic wrN,
    input wire logic cmdDataSelect,
    input wire logic controllerSelect,
    input wire logic [dcphp_pkg::DW-1:0] dataIn,
    output logic [dcphp_pkg::DW-1:0] dataOut,
    output logic dataOeN,
    // dma channels
    output logic hostDmaRequest,
    input wire logic hostDmaAckN,
    output logic devDmaRequest,
    input wire logic devDmaAckN,
    input wire logic endOfTransferInN
);
    import dcphp_pkg::*;

    localparam int AW = $clog2(FIFO_DEPTH);

    // three stage pin pipe; stage one only feeds stage two
    logic [PIN_W-1:0] pinS1_r, pinS2_r, pinS3_r, pinNow;
    // per controller state
    logic [7:0] index_r [2], index_nxt [2];
    logic [15:0] dmaCfg_r [2], dmaCfg_nxt [2];
    logic [15:0] xferCount_r [2], xferCount_nxt [2];
    logic [15:0] wordCnt_r [2], wordCnt_nxt [2];
    logic [15:0] dmaCnt_r [2], dmaCnt_nxt [2];
    logic [AW-1:0] ptr_r [2], ptr_nxt [2];
    logic dirSet_r [2], dirSet_nxt [2];
    logic dirWr_r [2], dirWr_nxt [2];
    logic half_r [2], half_nxt [2];
    logic [31:0] wide_r [2], wide_nxt [2];
    dcphp_dma_t dmaSt_r [2], dmaSt_nxt [2];
    // fifo storage, no reset needed
    logic [DW-1:0] fifoMem [2][FIFO_DEPTH];
    logic memWe;
    logic memCtl;
    logic [AW-1:0] memAddr;
    // decoded finished strobe and read path
    dcphp_acc_t acc;
    logic eotEvt;
    logic [DW-1:0] dataOut_nxt;
    logic dataOeN_nxt;

    // strips the write flag off an index
    function automatic logic [6:0] baseIdx(input logic [7:0] idx);
        return idx[6:0];
    endfunction

    // true when an index points at the fifo window
    function automatic logic isFifo(input logic [7:0] idx);
        return baseIdx(idx) == baseIdx(IDX_FIFO);
    endfunction

    assign pinNow = {endOfTransferInN, devDmaAckN, hostDmaAckN, controllerSelect,
                     cmdDataSelect, wrN, rdN, csN, dataIn};

    // pin synchroniser plus one stage for edge finding
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pinS1_r <= PINS_RST;
            pinS2_r <= PINS_RST;
            pinS3_r <= PINS_RST;
        end else begin
            pinS1_r <= pinNow;
            pinS2_r <= pinS1_r;
            pinS3_r <= pinS2_r;
        end
    end

    // decode a strobe at its release; address taken from the held stage
    always_comb begin
        logic ackAny;
        logic sel;
        ackAny = !pinS3_r[P_HACK] || !pinS3_r[P_DACK];
        sel = !pinS3_r[P_CS] || ackAny;
        acc.ctl = ackAny ? !pinS3_r[P_DACK] : pinS3_r[P_A1];
        acc.cmd = !ackAny && pinS3_r[P_A0];
        acc.dma = ackAny;
        acc.rd = sel && pinS2_r[P_RD] && !pinS3_r[P_RD];
        acc.wr = sel && pinS2_r[P_WR] && !pinS3_r[P_WR];
        acc.word = pinS3_r[DW-1:0];
        eotEvt = pinS3_r[P_EOT] && !pinS2_r[P_EOT];
    end

    // read path: drive the data port word while the read strobe is low
    always_comb begin
        logic ackNow;
        logic c;
        logic [7:0] idx;
        ackNow = !pinS2_r[P_HACK] || !pinS2_r[P_DACK];
        c = ackNow ? !pinS2_r[P_DACK] : pinS2_r[P_A1];
        idx = index_r[c];
        dataOeN_nxt = !(!pinS2_r[P_RD] && (ackNow || (!pinS2_r[P_CS] && !pinS2_r[P_A0])));
        // command ports are write only, so they never drive
        if (ackNow || isFifo(idx)) begin
            dataOut_nxt = fifoMem[c][ptr_r[c]];
        end else begin
            unique case (baseIdx(idx))
                baseIdx(IDX_DMA_CFG): dataOut_nxt = dmaCfg_r[c];
                baseIdx(IDX_XFER_CNT): dataOut_nxt = xferCount_r[c];
                baseIdx(IDX_CHIP_ID): dataOut_nxt = c ? WORD_ZERO : CHIP_ID;
                baseIdx(IDX_WIDE): dataOut_nxt = half_r[c] ? wide_r[c][31:16]
                                                           : wide_r[c][15:0];
                default: dataOut_nxt = WORD_ZERO;                     // unmapped reads zero
            endcase
        end
    end

    // next state of both controllers: index, registers, fifo and dma
    always_comb begin
        logic hit;
        logic [7:0] idx;
        logic fifoOk;
        hit = 1'b0;                 // recomputed per controller below
        idx = INDEX_RST;
        fifoOk = 1'b0;              // only meaningful inside a fifo data phase
        memWe = 1'b0;
        memCtl = acc.ctl;
        memAddr = ptr_r[acc.ctl];
        for (int c = 0; c < 2; c++) begin
            index_nxt[c] = index_r[c];
            dmaCfg_nxt[c] = dmaCfg_r[c];
            xferCount_nxt[c] = xferCount_r[c];
            wordCnt_nxt[c] = wordCnt_r[c];
            dmaCnt_nxt[c] = dmaCnt_r[c];
            ptr_nxt[c] = ptr_r[c];
            dirSet_nxt[c] = dirSet_r[c];
            dirWr_nxt[c] = dirWr_r[c];
            half_nxt[c] = half_r[c];
            wide_nxt[c] = wide_r[c];
            dmaSt_nxt[c] = dmaSt_r[c];
            hit = (acc.rd || acc.wr) && (acc.ctl == c[0]);
            idx = index_r[c];
            // dma channel: 0 is the host fifo, 1 the device fifo
            unique case (dmaSt_r[c])
                DMA_IDLE: begin
                    // enable opens a transfer and raises the request
                    if (dmaCfg_r[c][CFG_EN_BIT]) begin
                        dmaSt_nxt[c] = DMA_RUN;
                        dmaCnt_nxt[c] = WORD_ZERO;
                        ptr_nxt[c] = '0;
                    end
                end
                DMA_RUN: begin
                    // the master strobes; we only answer each cycle
                    if (hit && acc.dma && (acc.wr == dmaCfg_r[c][CFG_TO_FIFO_BIT])) begin
                        memWe = acc.wr;
                        ptr_nxt[c] = ptr_r[c] + 1'b1;
                        dmaCnt_nxt[c] = dmaCnt_r[c] + BYTES_PER_WORD;
                    end
                    if (eotEvt) begin
                        dmaSt_nxt[c] = DMA_DONE;
                    end else if (dmaCfg_r[c][CFG_CNT_SEL_BIT]
                                 && dmaCnt_nxt[c] == xferCount_r[c]) begin
                        dmaSt_nxt[c] = DMA_DONE;
                    end
                end
                DMA_DONE: begin
                    // hardware drops the enable; a software write below wins
                    dmaCfg_nxt[c][CFG_EN_BIT] = 1'b0;
                    dmaSt_nxt[c] = DMA_IDLE;
                end
                default: dmaSt_nxt[c] = DMA_IDLE;
            endcase
            if (hit && acc.cmd && acc.wr) begin
                // a new index restarts every multi phase sequence
                index_nxt[c] = acc.word[7:0];
                half_nxt[c] = 1'b0;
                wordCnt_nxt[c] = WORD_ZERO;
                ptr_nxt[c] = '0;
                dirSet_nxt[c] = 1'b0;
            end else if (hit && !acc.cmd && !acc.dma) begin
                // data phase acts on the last index of this controller
                if (isFifo(idx)) begin
                    // byte count bounds the cycle, first phase fixes direction
                    fifoOk = (wordCnt_r[c] < {1'b0, xferCount_r[c][15:1]})
                             && (!dirSet_r[c] || dirWr_r[c] == acc.wr);
                    if (fifoOk) begin
                        memWe = acc.wr;
                        ptr_nxt[c] = ptr_r[c] + 1'b1;
                        wordCnt_nxt[c] = wordCnt_r[c] + 16'h0001;
                        dirSet_nxt[c] = 1'b1;
                        dirWr_nxt[c] = acc.wr;
                    end
                end else begin
                    if (baseIdx(idx) == baseIdx(IDX_WIDE)) begin
                        half_nxt[c] = !half_r[c];
                    end
                    if (acc.wr && idx[IDX_WR_BIT]) begin
                        unique case (baseIdx(idx))
                            baseIdx(IDX_DMA_CFG): dmaCfg_nxt[c] = acc.word;
                            baseIdx(IDX_XFER_CNT): xferCount_nxt[c] = acc.word;
                            baseIdx(IDX_WIDE): begin
                                if (half_r[c]) begin
                                    wide_nxt[c][31:16] = acc.word;
                                end else begin
                                    wide_nxt[c][15:0] = acc.word;
                                end
                            end
                            default: ;                                   // id and unmapped ignore
                        endcase
                    end
                end
            end
        end
    end

    // control registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            for (int c = 0; c < 2; c++) begin
                index_r[c] <= INDEX_RST;
                dmaCfg_r[c] <= DMA_CFG_RST;
                xferCount_r[c] <= XFER_CNT_RST;
                wordCnt_r[c] <= WORD_ZERO;
                dmaCnt_r[c] <= WORD_ZERO;
                ptr_r[c] <= '0;
                dirSet_r[c] <= 1'b0;
                dirWr_r[c] <= 1'b0;
                half_r[c] <= 1'b0;
                wide_r[c] <= WIDE_RST;
                dmaSt_r[c] <= DMA_IDLE;
            end
            dataOut <= WORD_ZERO;
            dataOeN <= 1'b1;
            hostDmaRequest <= 1'b0;
            devDmaRequest <= 1'b0;
        end else begin
            for (int c = 0; c < 2; c++) begin
                index_r[c] <= index_nxt[c];
                dmaCfg_r[c] <= dmaCfg_nxt[c];
                xferCount_r[c] <= xferCount_nxt[c];
                wordCnt_r[c] <= wordCnt_nxt[c];
                dmaCnt_r[c] <= dmaCnt_nxt[c];
                ptr_r[c] <= ptr_nxt[c];
                dirSet_r[c] <= dirSet_nxt[c];
                dirWr_r[c] <= dirWr_nxt[c];
                half_r[c] <= half_nxt[c];
                wide_r[c] <= wide_nxt[c];
                dmaSt_r[c] <= dmaSt_nxt[c];
            end
            dataOut <= dataOut_nxt;
            dataOeN <= dataOeN_nxt;
            hostDmaRequest <= dmaSt_nxt[0] == DMA_RUN;
            devDmaRequest <= dmaSt_nxt[1] == DMA_RUN;
        end
    end

    // fifo write port, one word per finished strobe
    always_ff @(posedge clk) begin
        if (memWe) begin
            fifoMem[memCtl][memAddr] <= acc.word;
        end
    end

    // a command write lands in that controller's index
    property p_cmd_index;
        @(posedge clk) disable iff (!rstn)
        (acc.wr && acc.cmd && !acc.ctl) |=> (index_r[0] == $past(acc.word[7:0]));
    endproperty
    a_cmd_index: assert property (p_cmd_index) else $error("index not captured");

    // a selected data read drives the bus on the next cycle
    property p_read_drive;
        @(posedge clk) disable iff (!rstn)
        (!pinS2_r[P_RD] && !pinS2_r[P_CS] && !pinS2_r[P_A0]) |=> !dataOeN;
    endproperty
    a_read_drive: assert property (p_read_drive) else $error("data port not driven");

    // a command port read never drives
    property p_cmd_quiet;
        @(posedge clk) disable iff (!rstn)
        (pinS2_r[P_A0] && pinS2_r[P_HACK] && pinS2_r[P_DACK]) |=> dataOeN;
    endproperty
    a_cmd_quiet: assert property (p_cmd_quiet) else $error("command port drove bus");

    // external end drops a running host request within two cycles
    property p_ext_eot;
        @(posedge clk) disable iff (!rstn)
        (eotEvt && dmaSt_r[0] == DMA_RUN) |=> (dmaSt_r[0] == DMA_DONE) ##1 !hostDmaRequest;
    endproperty
    a_ext_eot: assert property (p_ext_eot) else $error("eot ignored");

    // counter reaching the byte count ends the transfer
    property p_int_eot;
        @(posedge clk) disable iff (!rstn)
        (dmaSt_r[0] == DMA_RUN && dmaCfg_r[0][CFG_CNT_SEL_BIT]
         && dmaCnt_nxt[0] == xferCount_r[0]) |=> ##[1:2] !hostDmaRequest;
    endproperty
    a_int_eot: assert property (p_int_eot) else $error("internal eot missed");

    // request stands exactly while the channel runs
    property p_request;
        @(posedge clk) disable iff (!rstn)
        hostDmaRequest == (dmaSt_r[0] == DMA_RUN) && devDmaRequest == (dmaSt_r[1] == DMA_RUN);
    endproperty
    a_request: assert property (p_request) else $error("request mismatch");

    // fifo phases stop at half the byte count
    property p_fifo_limit;
        @(posedge clk) disable iff (!rstn)
        (wordCnt_r[0] >= {1'b0, xferCount_r[0][15:1]} && acc.wr && !acc.ctl
         && !acc.cmd && !acc.dma) |=> $stable(wordCnt_r[0]) && $stable(ptr_r[0]);
    endproperty
    a_fifo_limit: assert property (p_fifo_limit) else $error("fifo past count");

    // each wide data phase flips the half
    property p_wide_half;
        @(posedge clk) disable iff (!rstn)
        ((acc.rd || acc.wr) && !acc.ctl && !acc.cmd && !acc.dma
         && baseIdx(index_r[0]) == baseIdx(IDX_WIDE)) |=> half_r[0] != $past(half_r[0]);
    endproperty
    a_wide_half: assert property (p_wide_half) else $error("half not toggled");

    // index 27h on the host reads the identification word
    property p_chip_id;
        @(posedge clk) disable iff (!rstn)
        (index_r[0] == IDX_CHIP_ID && !pinS2_r[P_A1] && pinS2_r[P_HACK]
         && pinS2_r[P_DACK]) |=> dataOut == CHIP_ID;
    endproperty
    a_chip_id: assert property (p_chip_id) else $error("wrong chip id");

endmodule // dcphp_host_port

/* hw/dcphp_pkg.sv */
/*
 * constants, types and pin layout for the dual controller parallel host port.
 * assumes one 50 mhz clock, an active low asynchronous reset and a processor
 * (plus its dma master) that drives the strobes slowly next to that clock.
 */
// Behaviour
// - CS and two lines pick four ports
// - two address lines reach all registers, FIFO
// - read strobe drives addressed data port word
// - write strobe captures command or data word
// - command is low byte register index
// - command phase then data phase, same controller
// - wide register: low half then high half
// - host index 27H reads chip identification
// - FIFO read as repeated data phases
// - byte count comes from transfer count register
// - channel 1 moves host FIFO data
// - channel 2 moves device FIFO data
// - external end of transfer stops DMA
// - DMA configuration enables internal transfer counter
// - counter equal byte count ends transfer
// - request raised at start of burst
// - DMA cycles repeat until end of transfer
package dcphp_pkg;

    // data bus width
    localparam int DW = 16;

    // port codes: {controller_select, cmd_data_select}
    localparam logic [1:0] PORT_HC_DATA = 2'h0;
    localparam logic [1:0] PORT_HC_CMD = 2'h1;
    localparam logic [1:0] PORT_DC_DATA = 2'h2;
    localparam logic [1:0] PORT_DC_CMD = 2'h3;

    // register indices, read form; write form sets IDX_WR_BIT
    localparam int IDX_WR_BIT = 7;
    localparam logic [7:0] IDX_DMA_CFG = 8'h21;
    localparam logic [7:0] IDX_XFER_CNT = 8'h22;
    localparam logic [7:0] IDX_CHIP_ID = 8'h27;
    localparam logic [7:0] IDX_WIDE = 8'h28;
    localparam logic [7:0] IDX_FIFO = 8'h40;

    // dma_configuration fields
    localparam int CFG_EN_BIT = 0;
    localparam int CFG_CNT_SEL_BIT = 1;
    localparam int CFG_TO_FIFO_BIT = 2;

    // reset values
    localparam logic [7:0] INDEX_RST = 8'h00;
    localparam logic [15:0] DMA_CFG_RST = 16'h0000;
    localparam logic [15:0] XFER_CNT_RST = 16'h0000;
    localparam logic [31:0] WIDE_RST = 32'h0000_0000;
    localparam logic [15:0] WORD_ZERO = 16'h0000;
    localparam logic [15:0] BYTES_PER_WORD = 16'h0002;

    // positions inside the synchronised pin vector
    localparam int PIN_W = 24;
    localparam int P_CS = 16;
    localparam int P_RD = 17;
    localparam int P_WR = 18;
    localparam int P_A0 = 19;
    localparam int P_A1 = 20;
    localparam int P_HACK = 21;
    localparam int P_DACK = 22;
    localparam int P_EOT = 23;
    localparam logic [PIN_W-1:0] PINS_RST = 24'hFF_0000;

    // dma channel state, one-hot
    typedef enum logic [2:0] {
        DMA_IDLE = 3'b001,
        DMA_RUN = 3'b010,
        DMA_DONE = 3'b100
    } dcphp_dma_t;

    // one finished strobe on the port
    typedef struct packed {
        logic ctl;
        logic cmd;
        logic dma;
        logic rd;
        logic wr;
        logic [DW-1:0] word;
    } dcphp_acc_t;

endpackage

/* tb/dcphp_cpu_model.sv */
/*
 * behavioural processor and system dma master on the far side of the port.
 * assumes the bench calls its tasks one at a time; every pin moves 1 ns
 * after a rising clock edge and is held at least three cycles.
 */
module dcphp_cpu_model (
    // clock
    input wire logic clk,
    // processor bus
    output logic csN,
    output logic rdN,
    output logic wrN,
    output logic cmdDataSelect,
    output logic controllerSelect,
    output logic [dcphp_pkg::DW-1:0] dataIn,
    input wire logic [dcphp_pkg::DW-1:0] dataOut,
    input wire logic dataOeN,
    // dma handshake
    output logic hostDmaAckN,
    output logic devDmaAckN,
    output logic endOfTransferInN
);
    timeunit 1ns;
    timeprecision 100ps;
    import dcphp_pkg::*;

    logic [DW-1:0] lastWord; // word last put on the bus
    logic drive; // processor owns the bus

    // a released bus shows the inverse, so a stale word never passes
    always_comb dataIn = drive ? lastWord : ~lastWord;

    // idle bus at time zero
    initial begin
        {csN, rdN, wrN, hostDmaAckN, devDmaAckN, endOfTransferInN} = 6'h3F;
        {cmdDataSelect, controllerSelect, drive} = 3'h0;
        lastWord = 16'h0000;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // setup 3, strobe low 5, hold 3, gap 3; strobes are slow next to clk
    task automatic strobe(input logic isRd, output logic [DW-1:0] got, output logic seen);
        step(3);
        if (isRd) rdN = 1'b0;
        else wrN = 1'b0;
        step(5);
        got = dataOut;
        seen = (dataOeN === 1'b0);
        if (isRd) rdN = 1'b1;
        else wrN = 1'b1;
        step(3);
        {csN, hostDmaAckN, devDmaAckN, drive} = 4'hE;
        step(3);
    endtask

    // one programmed access; address stays until the next access
    task automatic pio(input logic [1:0] port, input logic isRd, input logic [DW-1:0] word,
            output logic [DW-1:0] got, output logic seen);
        {controllerSelect, cmdDataSelect} = port;
        csN = 1'b0;
        lastWord = word;
        drive = !isRd;
        strobe(isRd, got, seen);
    endtask

    // index in low byte, high byte zero, always before the data phases
    task automatic cmd(input logic ctl, input logic [7:0] idx);
        logic [DW-1:0] g;
        logic s;
        pio({ctl, 1'b1}, 1'b0, {8'h00, idx}, g, s);
    endtask

    // master drives ack and strobe itself, chip select stays high
    task automatic dma(input logic ctl, input logic isRd, input logic [DW-1:0] word,
            output logic [DW-1:0] got);
        logic s;
        if (ctl) devDmaAckN = 1'b0;
        else hostDmaAckN = 1'b0;
        lastWord = word;
        drive = !isRd;
        strobe(isRd, got, s);
    endtask

    // external end of transfer pulse
    task automatic end_of_transfer_in();
        endOfTransferInN = 1'b0;
        step(4);
        endOfTransferInN = 1'b1;
        step(3);
    endtask
endmodule // dcphp_cpu_model

/* tb/dcphp_host_port_tb.sv */
/*
 * self-checking bench for the parallel host port: registers, fifo, dma.
 * assumes the cpu model for all pin timing and a 50 mhz clock.
 */
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("[ERR] %0t %s got %h want %h", $time, tname, g, e); end end
module dcphp_host_port_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import dcphp_pkg::*;

    localparam logic [15:0] TB_ID = 16'hC3A5; // arbitrary value
    logic clk, rstn, csN, rdN, wrN, cmdDataSelect, controllerSelect;
    logic [DW-1:0] dataIn, dataOut, g;
    logic dataOeN, hostDmaRequest, hostDmaAckN, devDmaRequest, devDmaAckN, endOfTransferInN;
    logic s;
    int n_fail = 0;
    int n_compared = 0;
    string tname = "reset";

    dcphp_host_port #(.CHIP_ID(TB_ID)) dcphp_host_port_inst (.clk(clk), .rstn(rstn),
        .csN(csN), .rdN(rdN), .wrN(wrN), .cmdDataSelect(cmdDataSelect),
        .controllerSelect(controllerSelect), .dataIn(dataIn), .dataOut(dataOut),
        .dataOeN(dataOeN), .hostDmaRequest(hostDmaRequest), .hostDmaAckN(hostDmaAckN),
        .devDmaRequest(devDmaRequest), .devDmaAckN(devDmaAckN),
        .endOfTransferInN(endOfTransferInN));
    dcphp_cpu_model dcphp_cpu_model_inst (.clk(clk), .csN(csN), .rdN(rdN), .wrN(wrN),
        .cmdDataSelect(cmdDataSelect), .controllerSelect(controllerSelect),
        .dataIn(dataIn), .dataOut(dataOut), .dataOeN(dataOeN), .hostDmaAckN(hostDmaAckN),
        .devDmaAckN(devDmaAckN), .endOfTransferInN(endOfTransferInN));

    // 20 ns clock
    always #10 clk = ~clk;

    task automatic pwr(input logic [1:0] p, input logic [DW-1:0] w);
        dcphp_cpu_model_inst.pio(p, 1'b0, w, g, s);
    endtask
    task automatic cmd(input logic c, input logic [7:0] i);
        dcphp_cpu_model_inst.cmd(c, i);
    endtask
    task automatic wreg(input logic c, input logic [7:0] i, input logic [DW-1:0] w);
        cmd(c, i | (8'h01 << IDX_WR_BIT));
        pwr({c, 1'b0}, w);
    endtask
    // data port read must be driven and carry the expected word
    task automatic rdata(input logic c, input logic [DW-1:0] e);
        dcphp_cpu_model_inst.pio({c, 1'b0}, 1'b1, WORD_ZERO, g, s);
        `CHK(s, 1'b1)
        `CHK(g, e)
    endtask
    task automatic rreg(input logic c, input logic [7:0] i, input logic [DW-1:0] e);
        cmd(c, i);
        rdata(c, e);
    endtask
    // bounded wait for a request; looked at 1 ns after an edge, never on it
    task automatic wait_req(input logic c);
        for (int k = 0; k < 20; k++) begin
            if ((c ? devDmaRequest : hostDmaRequest) === 1'b1) break;
            @(posedge clk);
            #1;
        end
    endtask
    task automatic dwr(input logic c, input logic [DW-1:0] w);
        dcphp_cpu_model_inst.dma(c, 1'b0, w, g);
    endtask

    task automatic t_chip_id();
        tname = "chip_id";
        rreg(1'b0, IDX_CHIP_ID, TB_ID);
        wreg(1'b0, IDX_CHIP_ID, 16'h0000);
        rreg(1'b0, IDX_CHIP_ID, TB_ID);
        // command port is write only: no drive on a read
        dcphp_cpu_model_inst.pio(PORT_HC_CMD, 1'b1, WORD_ZERO, g, s);
        `CHK(s, 1'b0)
        rreg(1'b1, IDX_CHIP_ID, WORD_ZERO);
        $display("test %s done", tname);
    endtask

    task automatic t_regs();
        tname = "regs";
        rreg(1'b0, IDX_DMA_CFG, DMA_CFG_RST);
        rreg(1'b0, IDX_XFER_CNT, XFER_CNT_RST);
        wreg(1'b0, IDX_XFER_CNT, 16'h1234);
        wreg(1'b1, IDX_XFER_CNT, 16'h0ABC);
        cmd(1'b0, IDX_XFER_CNT);
        pwr(PORT_HC_DATA, 16'hFFFF); // read-form index, write ignored
        rreg(1'b0, IDX_XFER_CNT, 16'h1234);
        rdata(1'b0, 16'h1234);
        rreg(1'b1, IDX_XFER_CNT, 16'h0ABC);
        rreg(1'b0, 8'h30, WORD_ZERO);
        $display("test %s done", tname);
    endtask

    task automatic t_wide();
        tname = "wide";
        cmd(1'b0, IDX_WIDE | 8'h80);
        pwr(PORT_HC_DATA, 16'h5AC3);
        pwr(PORT_HC_DATA, 16'h96E1);
        rreg(1'b0, IDX_WIDE, 16'h5AC3);
        rdata(1'b0, 16'h96E1);
        $display("test %s done", tname);
    endtask

    // odd count 7 allows three words; fourth write and reverse phase dropped
    task automatic t_fifo();
        tname = "fifo";
        wreg(1'b0, IDX_XFER_CNT, 16'h0007);
        cmd(1'b0, IDX_FIFO | 8'h80);
        for (int i = 0; i < 4; i++) pwr(PORT_HC_DATA, 16'(16'hA000 + i));
        cmd(1'b0, IDX_FIFO);
        rdata(1'b0, 16'hA000);
        pwr(PORT_HC_DATA, 16'hBEEF);
        cmd(1'b0, IDX_FIFO);
        for (int i = 0; i < 3; i++) rdata(1'b0, 16'(16'hA000 + i));
        $display("test %s done", tname);
    endtask

    // internal end of transfer after 4 bytes, both directions on channel 1
    task automatic t_dma_host();
        tname = "dma_host";
        wreg(1'b0, IDX_XFER_CNT, 16'h0004);
        wreg(1'b0, IDX_DMA_CFG, 16'h0007);
        wait_req(1'b0);
        `CHK(hostDmaRequest, 1'b1)
        `CHK(devDmaRequest, 1'b0)
        dwr(1'b0, 16'hD100);
        `CHK(hostDmaRequest, 1'b1)
        dwr(1'b0, 16'hD101);
        `CHK(hostDmaRequest, 1'b0)
        rreg(1'b0, IDX_DMA_CFG, 16'h0006);
        wreg(1'b0, IDX_DMA_CFG, 16'h0003);
        wait_req(1'b0);
        `CHK(hostDmaRequest, 1'b1)
        for (int i = 0; i < 2; i++) begin
            dcphp_cpu_model_inst.dma(1'b0, 1'b1, WORD_ZERO, g);
            `CHK(g, 16'hD100 + i)
        end
        `CHK(hostDmaRequest, 1'b0)
        $display("test %s done", tname);
    endtask

    // channel 2 runs until the external pulse, which also stops channel 1
    task automatic t_dma_dev();
        tname = "dma_dev";
        wreg(1'b1, IDX_DMA_CFG, 16'h0005);
        wait_req(1'b1);
        `CHK(devDmaRequest, 1'b1)
        `CHK(hostDmaRequest, 1'b0)
        for (int i = 0; i < 3; i++) dwr(1'b1, 16'(16'hE000 + i));
        `CHK(devDmaRequest, 1'b1)
        // host channel without counter, so only the pulse can end it
        wreg(1'b0, IDX_DMA_CFG, 16'h0001);
        wait_req(1'b0);
        `CHK(hostDmaRequest, 1'b1)
        dcphp_cpu_model_inst.end_of_transfer_in();
        `CHK(devDmaRequest, 1'b0)
        `CHK(hostDmaRequest, 1'b0)
        wreg(1'b1, IDX_XFER_CNT, 16'h0006);
        cmd(1'b1, IDX_FIFO);
        for (int i = 0; i < 3; i++) rdata(1'b1, 16'(16'hE000 + i));
        $display("test %s done", tname);
    endtask

    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, several times the expected run
    initial begin
        #200us;
        n_fail++;
        finish_test();
    end

    // main sequence
    initial begin
        clk = 1'b0;
        rstn = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        `CHK(dataOeN, 1'b1)
        `CHK(hostDmaRequest | devDmaRequest, 1'b0)
        rstn = 1'b1;
        repeat (3) @(posedge clk);
        #1;
        t_chip_id();
        t_regs();
        t_wide();
        t_fifo();
        t_dma_host();
        t_dma_dev();
        finish_test();
    end
endmodule // dcphp_host_port_tb
